// >>> tmr_pkg.sv
// Package for the dual timer/counter unit: register offsets, field layouts, timing.
// Assumes a core that reaches the unit over a plain strobe register port.
package tmr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_RUN_FLAG   = 8'h88;
	localparam logic [7:0] OFS_MODE_SEL   = 8'h89;
	localparam logic [7:0] OFS_CNT_LOW0   = 8'h8a;
	localparam logic [7:0] OFS_CNT_LOW1   = 8'h8b;
	localparam logic [7:0] OFS_CNT_HIGH0  = 8'h8c;
	localparam logic [7:0] OFS_CNT_HIGH1  = 8'h8d;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h91;
	localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h92;
	localparam logic [7:0] OFS_IRQ_ACK    = 8'h93;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_RUN_FLAG = 8'h00;
	localparam logic [7:0] RST_MODE_SEL = 8'h00;
	localparam logic [7:0] RST_COUNT    = 8'h00;
	localparam logic [3:0] RST_IRQ      = 4'h0;

	// ------------------------------------------------------------
	// Run/flag register bit positions
	// ------------------------------------------------------------
	localparam int BIT_OVF1  = 7;
	localparam int BIT_RUN1  = 6;
	localparam int BIT_OVF0  = 5;
	localparam int BIT_RUN0  = 4;
	localparam int BIT_EDGE1 = 3;
	localparam int BIT_TYPE1 = 2;
	localparam int BIT_EDGE0 = 1;
	localparam int BIT_TYPE0 = 0;

	// Interrupt status layout: ovf0, ovf1, edge0, edge1
	localparam int IRQ_OVF0  = 0;
	localparam int IRQ_OVF1  = 1;
	localparam int IRQ_EDGE0 = 2;
	localparam int IRQ_EDGE1 = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ         = 250;
	localparam int CLKS_PER_PHASE  = 1;
	localparam int PHASES_PER_MC   = 12;
	localparam int CLKS_PER_MC     = CLKS_PER_PHASE * PHASES_PER_MC;
	localparam logic [3:0] SAMPLE_PHASE = 4'h9;   // Phase T10, zero based
	localparam logic [3:0] LAST_PHASE   = 4'hb;

	// Mode control half: gate, counter select, mode pair
	typedef struct packed {
		logic       gate;
		logic       counter_sel;
		logic       mode_bit_hi;
		logic       mode_bit_lo;
	} mode_half_type;

	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_AUTO8,
		MODE_SPLIT
	} timer_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;

endpackage : tmr_pkg

// >>> dual_timer_counter_unit.sv
// Dual 16-bit timer/counter with external interrupt edge flags.
// Assumes one 250 MHz clock; a machine cycle is twelve clocks from an internal divider.
//
// What this block does
// - Timer operation advances the count once per machine cycle while enabled.
// - Counter operation counts falling edges of count pin, sampled at phase T10.
// - Edge needs two machine-cycle samples; source holds each level one machine cycle.
// - Mode pair selects 13-bit, 16-bit, 8-bit auto-reload or split mode.
// - Mode 0: five low bits prescale by 32 into the high byte.
// - Roll over to zero sets that timer's overflow flag.
// - Count only while run bit set and gate clear or irq pin high; the mode 3 high byte ignores the gate.
// - Mode 1 counts all sixteen bits with no prescaler.
// - Mode 2 reloads low byte from high byte on overflow; high byte kept.
// - Timer 1 stops when its mode bits are both one.
// - Counter select one means counter, zero timer; bit 6 and bit 2.
// - Mode register: timer 1 in bits 7..4, timer 0 in 3..0.
// - Overflow flags bits 7 and 5, cleared when the core acknowledges.
// - Software run bits 6 and 4 turn each timer on or off.
// - Edge flags bits 3 and 1 set on irq edge, cleared on acknowledge.
// - Type bits 2 and 0 select falling edge when set, low level when clear.
// - Mode 3: timer 0 bytes split; high byte uses timer 1 run and flag.
`timescale 1ns/1ns
module dual_timer_counter_unit (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       ext_irq_pin_zero_n_i,
	input  wire logic       ext_irq_pin_one_n_i,
	input  wire logic       count_input_zero_i,
	input  wire logic       count_input_one_i,
	input  wire logic       ack_ovf_zero_i,
	input  wire logic       ack_ovf_one_i,
	input  wire logic       ack_edge_zero_i,
	input  wire logic       ack_edge_one_i,
	output logic            ext_irq_req_zero_o,
	output logic            ext_irq_req_one_o,
	output logic            irq_o
);

	// ------------------------------------------------------------
	// Types and functions
	// ------------------------------------------------------------
	tmr_pkg::reg_req_type req;
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	function automatic tmr_pkg::timer_mode_type mode_of(input tmr_pkg::mode_half_type h);
		mode_of = tmr_pkg::timer_mode_type'({h.mode_bit_hi, h.mode_bit_lo});
	endfunction : mode_of

	function automatic logic wr_hit(input tmr_pkg::reg_req_type r, input logic [7:0] ofs);
		wr_hit = r.wr && (r.addr == ofs);
	endfunction : wr_hit

	// ------------------------------------------------------------
	// Machine cycle divider
	// ------------------------------------------------------------
	logic [3:0] phase;
	logic       sample_en;
	logic       mc_en;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || phase == tmr_pkg::LAST_PHASE) begin
			phase <= 4'h0;
		end else begin
			phase <= phase + 4'h1;
		end
	end
	assign sample_en = (phase == tmr_pkg::SAMPLE_PHASE);
	assign mc_en     = (phase == tmr_pkg::LAST_PHASE);

	// ------------------------------------------------------------
	// Pin synchronisers: three flops, change counts when 2 and 3 agree
	// ------------------------------------------------------------
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_q;   // Filtered: irq1_n, irq0_n, cnt1, cnt0

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			// Idle-high reset, so no false edge follows reset
			pin_s1 <= 4'hf;
			pin_s2 <= 4'hf;
			pin_s3 <= 4'hf;
			pin_q  <= 4'hf;
		end else begin
			pin_s1 <= {ext_irq_pin_one_n_i, ext_irq_pin_zero_n_i, count_input_one_i, count_input_zero_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < 4; i++) begin
				if (pin_s2[i] == pin_s3[i]) begin
					pin_q[i] <= pin_s3[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Once-per-machine-cycle samples at T10
	// ------------------------------------------------------------
	logic [3:0] samp;
	logic [3:0] samp_prev;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			samp      <= 4'hf;
			samp_prev <= 4'hf;
		end else if (sample_en) begin
			samp      <= pin_q;
			samp_prev <= samp;
		end
	end

	// One sample high then one low: two machine cycles per event
	logic cnt_fall0;
	logic cnt_fall1;
	logic irq_fall0;
	logic irq_fall1;
	assign cnt_fall0 = samp_prev[0] && !samp[0];
	assign cnt_fall1 = samp_prev[1] && !samp[1];
	assign irq_fall0 = samp_prev[2] && !samp[2];
	assign irq_fall1 = samp_prev[3] && !samp[3];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] run_flag;
	logic [7:0] mode_sel;
	logic [7:0] count_low_byte_zero;
	logic [7:0] count_high_byte_zero;
	logic [7:0] count_low_byte_one;
	logic [7:0] count_high_byte_one;
	logic [3:0] irq_enable;

	tmr_pkg::mode_half_type half0;
	tmr_pkg::mode_half_type half1;
	tmr_pkg::timer_mode_type mode0;
	tmr_pkg::timer_mode_type mode1;
	assign half0 = mode_sel[3:0];
	assign half1 = mode_sel[7:4];
	assign mode0 = mode_of(half0);
	assign mode1 = mode_of(half1);

	// ------------------------------------------------------------
	// Count enables
	// ------------------------------------------------------------
	logic run0;
	logic run1;
	logic step0;
	logic step1;
	logic step_hi0;

	// Gate opens while the irq pin sits high, its idle level
	assign run0 = run_flag[tmr_pkg::BIT_RUN0] && (!half0.gate || samp[2]);
	assign run1 = run_flag[tmr_pkg::BIT_RUN1] && (!half1.gate || samp[3])
		&& mode1 != tmr_pkg::MODE_SPLIT;

	// Counter select picks the falling-edge tick, else every machine cycle
	assign step0 = run0 && (half0.counter_sel ? (mc_en && cnt_fall0) : mc_en);
	assign step1 = run1 && (half1.counter_sel ? (mc_en && cnt_fall1) : mc_en);
	// Split high byte always counts machine cycles under timer 1 run bit
	assign step_hi0 = run_flag[tmr_pkg::BIT_RUN1] && mc_en;

	// ------------------------------------------------------------
	// Next count values and overflow events
	// ------------------------------------------------------------
	logic [7:0] next_low0;
	logic [7:0] next_high0;
	logic [7:0] next_low1;
	logic [7:0] next_high1;
	logic       ovf0;
	logic       ovf1;

	function automatic logic [16:0] advance(input tmr_pkg::timer_mode_type m, input logic [7:0] lo,
		input logic [7:0] hi, input logic step);
		logic [5:0] pre;
		logic [8:0] hsum;
		logic [8:0] lsum;
		logic [16:0] full;
		pre  = {1'b0, lo[4:0]} + 6'h01;
		hsum = {1'b0, hi} + 9'h001;
		lsum = {1'b0, lo} + 9'h001;
		full = {1'b0, hi, lo} + 17'h00001;
		advance = {1'b0, hi, lo};
		if (step) begin
			case (m)
				tmr_pkg::MODE_13BIT: begin
					advance = {pre[5] && hsum[8], pre[5] ? hsum[7:0] : hi, lo[7:5], pre[4:0]};
				end
				tmr_pkg::MODE_16BIT: begin
					advance = full;
				end
				tmr_pkg::MODE_AUTO8: begin
					advance = {lsum[8], hi, lsum[8] ? hi : lsum[7:0]};
				end
				tmr_pkg::MODE_SPLIT: begin
					advance = {lsum[8], hi, lsum[7:0]};
				end
				default: begin
					advance = {1'b0, hi, lo};
				end
			endcase
		end
	endfunction : advance

	logic [16:0] adv0;
	logic [16:0] adv1;
	logic [8:0]  hi_split;
	assign adv0 = advance(mode0, count_low_byte_zero, count_high_byte_zero, step0);
	assign adv1 = advance(mode1, count_low_byte_one, count_high_byte_one, step1);
	assign hi_split = {1'b0, count_high_byte_zero} + 9'h001;

	always_comb begin
		next_low0  = adv0[7:0];
		next_high0 = adv0[15:8];
		next_low1  = adv1[7:0];
		next_high1 = adv1[15:8];
		ovf0       = adv0[16];
		ovf1       = adv1[16];
		if (mode0 == tmr_pkg::MODE_SPLIT) begin
			next_high0 = step_hi0 ? hi_split[7:0] : count_high_byte_zero;
			ovf1       = step_hi0 && hi_split[8];
		end
	end

	// ------------------------------------------------------------
	// Count registers: software write takes the cycle over counting
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count_low_byte_zero  <= tmr_pkg::RST_COUNT;
			count_high_byte_zero <= tmr_pkg::RST_COUNT;
			count_low_byte_one   <= tmr_pkg::RST_COUNT;
			count_high_byte_one  <= tmr_pkg::RST_COUNT;
		end else begin
			count_low_byte_zero  <= wr_hit(req, tmr_pkg::OFS_CNT_LOW0) ? req.wdata : next_low0;
			count_high_byte_zero <= wr_hit(req, tmr_pkg::OFS_CNT_HIGH0) ? req.wdata : next_high0;
			count_low_byte_one   <= wr_hit(req, tmr_pkg::OFS_CNT_LOW1) ? req.wdata : next_low1;
			count_high_byte_one  <= wr_hit(req, tmr_pkg::OFS_CNT_HIGH1) ? req.wdata : next_high1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_sel <= tmr_pkg::RST_MODE_SEL;
		end else if (wr_hit(req, tmr_pkg::OFS_MODE_SEL)) begin
			mode_sel <= req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Run/flag register: hardware set wins over software or ack clear
	// ------------------------------------------------------------
	logic [7:0] next_run_flag;
	logic       edge_set0;
	logic       edge_set1;

	// Edge type latches falling edges; level type sets the flag while the pin samples low
	assign edge_set0 = run_flag[tmr_pkg::BIT_TYPE0] ? (mc_en && irq_fall0) : !samp[2];
	assign edge_set1 = run_flag[tmr_pkg::BIT_TYPE1] ? (mc_en && irq_fall1) : !samp[3];

	always_comb begin
		next_run_flag = run_flag;
		if (wr_hit(req, tmr_pkg::OFS_RUN_FLAG)) begin
			next_run_flag = req.wdata;
		end
		if (ack_ovf_zero_i) begin
			next_run_flag[tmr_pkg::BIT_OVF0] = 1'b0;
		end
		if (ack_ovf_one_i) begin
			next_run_flag[tmr_pkg::BIT_OVF1] = 1'b0;
		end
		if (ack_edge_zero_i) begin
			next_run_flag[tmr_pkg::BIT_EDGE0] = 1'b0;
		end
		if (ack_edge_one_i) begin
			next_run_flag[tmr_pkg::BIT_EDGE1] = 1'b0;
		end
		if (ovf0) begin
			next_run_flag[tmr_pkg::BIT_OVF0] = 1'b1;
		end
		if (ovf1) begin
			next_run_flag[tmr_pkg::BIT_OVF1] = 1'b1;
		end
		if (edge_set0) begin
			next_run_flag[tmr_pkg::BIT_EDGE0] = 1'b1;
		end
		if (edge_set1) begin
			next_run_flag[tmr_pkg::BIT_EDGE1] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			run_flag <= tmr_pkg::RST_RUN_FLAG;
		end else begin
			run_flag <= next_run_flag;
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, enable and clear
	// ------------------------------------------------------------
	logic [3:0] irq_status;
	logic [3:0] irq_events;
	assign irq_events = {edge_set1 && !run_flag[tmr_pkg::BIT_EDGE1], edge_set0 && !run_flag[tmr_pkg::BIT_EDGE0],
		ovf1, ovf0};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_status <= tmr_pkg::RST_IRQ;
		end else begin
			// Event set beats a clear in the same cycle
			irq_status <= (irq_status & ~(wr_hit(req, tmr_pkg::OFS_IRQ_CLEAR) ? req.wdata[3:0] : 4'h0))
				| irq_events;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_enable <= tmr_pkg::RST_IRQ;
		end else if (wr_hit(req, tmr_pkg::OFS_IRQ_ENABLE)) begin
			irq_enable <= req.wdata[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_o              <= 1'b0;
			ext_irq_req_zero_o <= 1'b0;
			ext_irq_req_one_o  <= 1'b0;
		end else begin
			irq_o              <= |(next_irq_status() & irq_enable);
			ext_irq_req_zero_o <= next_run_flag[tmr_pkg::BIT_EDGE0];
			ext_irq_req_one_o  <= next_run_flag[tmr_pkg::BIT_EDGE1];
		end
	end

	function automatic logic [3:0] next_irq_status();
		next_irq_status = (irq_status & ~(wr_hit(req, tmr_pkg::OFS_IRQ_CLEAR) ? req.wdata[3:0] : 4'h0))
			| irq_events;
	endfunction : next_irq_status

	// ------------------------------------------------------------
	// Read port: data one cycle after the strobe, zero otherwise
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !req.rd) begin
			rdata_o <= 8'h00;
		end else begin
			case (req.addr)
				tmr_pkg::OFS_RUN_FLAG:   rdata_o <= run_flag;
				tmr_pkg::OFS_MODE_SEL:   rdata_o <= mode_sel;
				tmr_pkg::OFS_CNT_LOW0:   rdata_o <= count_low_byte_zero;
				tmr_pkg::OFS_CNT_HIGH0:  rdata_o <= count_high_byte_zero;
				tmr_pkg::OFS_CNT_LOW1:   rdata_o <= count_low_byte_one;
				tmr_pkg::OFS_CNT_HIGH1:  rdata_o <= count_high_byte_one;
				tmr_pkg::OFS_IRQ_STATUS: rdata_o <= {4'h0, irq_status};
				tmr_pkg::OFS_IRQ_ENABLE: rdata_o <= {4'h0, irq_enable};
				default:                 rdata_o <= 8'h00;
			endcase
		end
	end

endmodule : dual_timer_counter_unit

// >>> dual_timer_counter_unit_props.sv
// Checker for the dual timer/counter unit, seeing only its top ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ns
module dual_timer_counter_unit_props (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       ext_irq_pin_zero_n_i,
	input wire logic       ext_irq_pin_one_n_i,
	input wire logic       count_input_zero_i,
	input wire logic       count_input_one_i,
	input wire logic       ack_ovf_zero_i,
	input wire logic       ack_ovf_one_i,
	input wire logic       ack_edge_zero_i,
	input wire logic       ack_edge_one_i,
	input wire logic       ext_irq_req_zero_o,
	input wire logic       ext_irq_req_one_o,
	input wire logic       irq_o
);
	logic [7:0] mode_sh;
	logic [7:0] ctl_sh;
	logic [3:0] en_sh;
	logic [5:0] hi_cnt0;
	logic       wr_ctl;

	assign wr_ctl = wr_i && addr_i == tmr_pkg::OFS_RUN_FLAG;

	// ------------------------------------------------------------
	// Shadows of software state
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_sh <= 8'h00;
			ctl_sh  <= 8'h00;
			en_sh   <= 4'h0;
		end else if (wr_i) begin
			if (addr_i == tmr_pkg::OFS_MODE_SEL) mode_sh <= wdata_i;
			if (wr_ctl) ctl_sh <= wdata_i;
			if (addr_i == tmr_pkg::OFS_IRQ_ENABLE) en_sh <= wdata_i[3:0];
		end
	end

	// Saturating run length of the idle-high interrupt pin
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !ext_irq_pin_zero_n_i) hi_cnt0 <= 6'h00;
		else if (hi_cnt0 != 6'h3f) hi_cnt0 <= hi_cnt0 + 6'h01;
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_read_idle: assert property (rdata_o != 8'h00 |-> $past(rd_i))
		else $error("read data seen without a read");
	chk_unmapped_zero: assert property (rd_i && !(addr_i inside {[8'h88:8'h8d], 8'h90, 8'h91}) |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_mode_readback: assert property (rd_i && addr_i == tmr_pkg::OFS_MODE_SEL |=> rdata_o == mode_sh)
		else $error("mode register readback wrong");
	chk_ctl_readback: assert property (rd_i && wr_ctl == 1'b0 && addr_i == tmr_pkg::OFS_RUN_FLAG
		|=> {rdata_o[6], rdata_o[4], rdata_o[2], rdata_o[0]} == {ctl_sh[6], ctl_sh[4], ctl_sh[2], ctl_sh[0]})
		else $error("run or type bits readback wrong");
	chk_enable_readback: assert property (rd_i && addr_i == tmr_pkg::OFS_IRQ_ENABLE |=> rdata_o[3:0] == en_sh)
		else $error("interrupt enable readback wrong");
	chk_irq_masked: assert property (irq_o |-> $past(en_sh) != 4'h0)
		else $error("interrupt raised with all sources masked");
	chk_edge_cause: assert property ($rose(ext_irq_req_zero_o) |-> hi_cnt0 < 6'h20 || $past(wr_ctl) || $past(wr_ctl, 2))
		else $error("edge flag set with pin idle");
	chk_ack_clears: assert property (ack_edge_zero_i && hi_cnt0 >= 6'h20 && !wr_ctl |=> !ext_irq_req_zero_o)
		else $error("edge flag not cleared by acknowledge");
endmodule : dual_timer_counter_unit_props

bind dual_timer_counter_unit dual_timer_counter_unit_props chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.ext_irq_pin_zero_n_i(ext_irq_pin_zero_n_i), .ext_irq_pin_one_n_i(ext_irq_pin_one_n_i),
	.count_input_zero_i(count_input_zero_i), .count_input_one_i(count_input_one_i),
	.ack_ovf_zero_i(ack_ovf_zero_i), .ack_ovf_one_i(ack_ovf_one_i), .ack_edge_zero_i(ack_edge_zero_i),
	.ack_edge_one_i(ack_edge_one_i), .ext_irq_req_zero_o(ext_irq_req_zero_o),
	.ext_irq_req_one_o(ext_irq_req_one_o), .irq_o(irq_o));

// >>> tmr_pin_model.sv
// Far-side pin model: count pins and active-low interrupt pins.
// Assumes the bench calls its tasks; idle levels are high, as with pull-ups.
`timescale 1ns/1ns
module tmr_pin_model (
	input  wire logic clk_i,
	output logic      count_zero_o,
	output logic      count_one_o,
	output logic      irq_zero_n_o,
	output logic      irq_one_n_o
);
	initial begin
		count_zero_o = 1'b1;
		count_one_o  = 1'b1;
		irq_zero_n_o = 1'b1;
		irq_one_n_o  = 1'b1;
	end

	// Each level held two machine cycles so every sample sees it
	task automatic count_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			count_zero_o <= 1'b0;
			repeat (2 * tmr_pkg::CLKS_PER_MC) @(posedge clk_i);
			count_zero_o <= 1'b1;
			repeat (2 * tmr_pkg::CLKS_PER_MC) @(posedge clk_i);
		end
	endtask : count_pulses

	task automatic set_irq_zero(input logic v);
		@(posedge clk_i);
		irq_zero_n_o <= v;
	endtask : set_irq_zero

	task automatic set_irq_one(input logic v);
		@(posedge clk_i);
		irq_one_n_o <= v;
	endtask : set_irq_one
endmodule : tmr_pin_model

// >>> dual_timer_counter_unit_tb_top.sv
// Self-checking bench for the dual timer/counter unit.
// Assumes the pin model on the far side and the bound checker.
`timescale 1ns/1ns
module dual_timer_counter_unit_tb_top;
	localparam logic [7:0] CTL = tmr_pkg::OFS_RUN_FLAG;
	localparam logic [7:0] MOD = tmr_pkg::OFS_MODE_SEL;
	localparam logic [7:0] LO0 = tmr_pkg::OFS_CNT_LOW0;
	localparam logic [7:0] HI0 = tmr_pkg::OFS_CNT_HIGH0;
	localparam logic [7:0] STA = tmr_pkg::OFS_IRQ_STATUS;
	localparam logic [7:0] ENA = tmr_pkg::OFS_IRQ_ENABLE;
	localparam logic [7:0] CLR = tmr_pkg::OFS_IRQ_CLEAR;
	logic       clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       ack_ovf = 1'b0;
	logic       ack_edge = 1'b0;
	logic       ack_ovf1 = 1'b0;
	logic       ack_edge1 = 1'b0;
	logic [7:0] rdata;
	logic       pin0, pin1, cnt0, cnt1, req0, req1, irq;
	logic [7:0] d;
	int         n_errors = 0;
	int         comparisons = 0;
	int         cyc = 0;
	int         t0;
	// Mode, low, high, expected low, expected high
	logic [7:0] tab [3][5] = '{'{8'h00, 8'hff, 8'hff, 8'he0, 8'h00}, '{8'h01, 8'hff, 8'hff, 8'h00, 8'h00},
		'{8'h02, 8'hff, 8'hf0, 8'hf0, 8'hf0}};

	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	tmr_pin_model pins (.clk_i(clk_i), .count_zero_o(cnt0), .count_one_o(cnt1), .irq_zero_n_o(pin0),
		.irq_one_n_o(pin1));
	dual_timer_counter_unit dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .ext_irq_pin_zero_n_i(pin0), .ext_irq_pin_one_n_i(pin1),
		.count_input_zero_i(cnt0), .count_input_one_i(cnt1), .ack_ovf_zero_i(ack_ovf), .ack_ovf_one_i(ack_ovf1),
		.ack_edge_zero_i(ack_edge), .ack_edge_one_i(ack_edge1), .ext_irq_req_zero_o(req0),
		.ext_irq_req_one_o(req1), .irq_o(irq));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check8
	task automatic check1(input string name, input logic exp, input logic got);
		check8(name, {7'h00, exp}, {7'h00, got});
	endtask : check1
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check8(name, exp, v);
	endtask : rd_chk
	task automatic irq_chk(input string name, input logic exp);
		repeat (3) @(posedge clk_i);
		#1 check1(name, exp, irq);
	endtask : irq_chk
	// Bounded wait for the interrupt output
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			#1 n++;
		end
		check1("irq_wait", 1'b1, irq);
	endtask : wait_irq
	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	initial begin
		#80000;
		n_errors++;
		final_report();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int a = 8'h88; a <= 8'h93; a++) rd_chk("reset", 8'(a), 8'h00);
		rd_chk("unmapped", 8'h8f, 8'h00);
		wr(STA, 8'hff);
		rd_chk("status_ro", STA, 8'h00);
		wr(MOD, 8'ha5);
		rd_chk("mode", MOD, 8'ha5);
		wr(CTL, 8'h55);
		rd_chk("run_type", CTL, 8'h55);
		wr(CTL, 8'h00);
		done("registers");
		wr(ENA, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(MOD, tab[i][0]);
			wr(LO0, tab[i][1]);
			wr(HI0, tab[i][2]);
			wr(CTL, 8'h10);
			wait_irq();
			wr(CTL, 8'h20);
			rd_chk("low0", LO0, tab[i][3]);
			rd_chk("high0", HI0, tab[i][4]);
			rd_chk("status", STA, 8'h01);
			wr(ENA, 8'h00);
			irq_chk("masked", 1'b0);
			wr(ENA, 8'h01);
			irq_chk("unmasked", 1'b1);
			wr(CLR, 8'h01);
			irq_chk("cleared", 1'b0);
			wr(CTL, 8'h00);
		end
		done("modes");
		wr(MOD, 8'h02);
		wr(HI0, 8'hff);
		wr(LO0, 8'hff);
		wr(CTL, 8'h10);
		wait_irq();
		t0 = cyc;
		wr(CLR, 8'h01);
		irq_chk("period_gap", 1'b0);
		wait_irq();
		check8("step_period", 8'h0c, 8'(cyc - t0));
		wr(CTL, 8'h20);
		@(posedge clk_i);
		ack_ovf <= 1'b1;
		@(posedge clk_i);
		ack_ovf <= 1'b0;
		rd_chk("ovf_ack", CTL, 8'h00);
		wr(CLR, 8'h0f);
		done("period");
		wr(MOD, 8'h33);
		wr(LO0, 8'h55);
		wr(HI0, 8'hff);
		wr(tmr_pkg::OFS_CNT_LOW1, 8'hff);
		wr(ENA, 8'h02);
		wr(CTL, 8'h40);
		wait_irq();
		rd_chk("split_flag", CTL, 8'hc0);
		@(posedge clk_i);
		ack_ovf1 <= 1'b1;
		@(posedge clk_i);
		ack_ovf1 <= 1'b0;
		rd_chk("split_ack", CTL, 8'h40);
		wr(CTL, 8'h00);
		rd_chk("split_high", HI0, 8'h00);
		rd_chk("split_low", LO0, 8'h55);
		rd_chk("t1_stopped", tmr_pkg::OFS_CNT_LOW1, 8'hff);
		wr(CLR, 8'h0f);
		done("split");
		wr(MOD, 8'h05);
		wr(LO0, 8'h00);
		wr(HI0, 8'h00);
		wr(CTL, 8'h10);
		pins.count_pulses(3);
		repeat (40) @(posedge clk_i);
		rd_chk("edges", LO0, 8'h03);
		pins.set_irq_zero(1'b0);
		repeat (24) @(posedge clk_i);
		wr(MOD, 8'h09);
		wr(LO0, 8'h00);
		repeat (48) @(posedge clk_i);
		rd_chk("gate_shut", LO0, 8'h00);
		check1("level_irq", 1'b1, req0);
		pins.set_irq_zero(1'b1);
		repeat (48) @(posedge clk_i);
		rd(LO0, d);
		check1("gate_open", 1'b1, d != 8'h00);
		wr(CTL, 8'h01);
		pins.set_irq_zero(1'b0);
		repeat (24) @(posedge clk_i);
		pins.set_irq_zero(1'b1);
		repeat (48) @(posedge clk_i);
		#1 check1("edge_held", 1'b1, req0);
		@(posedge clk_i);
		ack_edge <= 1'b1;
		@(posedge clk_i);
		ack_edge <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 check1("edge_ack", 1'b0, req0);
		wr(CTL, 8'h04);
		pins.set_irq_one(1'b0);
		repeat (24) @(posedge clk_i);
		pins.set_irq_one(1'b1);
		repeat (48) @(posedge clk_i);
		#1 check1("edge_held_one", 1'b1, req1);
		@(posedge clk_i);
		ack_edge1 <= 1'b1;
		@(posedge clk_i);
		ack_edge1 <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 check1("edge_ack_one", 1'b0, req1);
		done("pins");
		final_report();
	end
endmodule : dual_timer_counter_unit_tb_top
